// >>> pac_defs.svh
`ifndef PAC_DEFS_SVH
`define PAC_DEFS_SVH
// Register byte offsets within a quadrant (one word each)
`define PAC_REG_CTRL 4'h0
`define PAC_REG_STAT 4'h4
`define PAC_REG_FLAG 4'h8
`define PAC_REG_SWRST 4'hC
// Control word field positions
`define PAC_B_IRQ_EN 0
`define PAC_B_IRQ_POLARITY 1
`define PAC_B_BAD_POL 2
`define PAC_B_IRQ_MASK 3
`define PAC_B_LOL_EN 4
`define PAC_B_LOCK_LOSS_POLARITY 5
`define PAC_B_PIN_SEL 6
`define PAC_B_REG_SEL 7
`define PAC_B_AUTO 8
`define PAC_B_ACT_EN 9
`define PAC_B_PROG 10
`define PAC_CTRL_W 11
`define PAC_CTRL_RST 11'h000
// Status word field positions
`define PAC_S_LOCK_LOSS 0
`define PAC_S_ACTIVE 1
`define PAC_S_ALARM 2
`define PAC_S_SEL 3
`define PAC_S_RESET 4
`define PAC_STAT_W 5
// Software reset hold, in microseconds, and its count at 125 MHz
`define PAC_SWRST_US 10000
`define PAC_CLK_MHZ 125
`define PAC_SWRST_CYC (`PAC_SWRST_US * `PAC_CLK_MHZ)
`endif

// >>> pac_pkg.sv
package pac_pkg;
	// Two-signal form (output and enable) of a two-way or tri-state pin
	typedef struct packed {
		logic o;
		logic oe;
	} pac_pin_t;
	// Alarm inputs of one quadrant
	typedef struct packed {
		logic lock_loss;
		logic signal_loss_alarm1;
		logic frequency_offset_alarm1;
		logic signal_loss_alarm2;
		logic frequency_offset_alarm2;
	} pac_alarm_t;
	typedef enum logic [1:0] {PAC_IDLE, PAC_HOLD} pac_rst_state_t;
endpackage

// >>> pac_quadrant.sv
`timescale 1ns/100ps
`default_nettype none
`include "pac_defs.svh"
// Pin logic of one quadrant; all outputs are registered
module pac_quadrant (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic qrst_n,
	input wire logic [`PAC_CTRL_W-1:0] ctrl,
	input wire pac_pkg::pac_alarm_t alarm,
	input wire logic select_pin_in,
	output pac_pkg::pac_pin_t irq_pin,
	output pac_pkg::pac_pin_t lock_loss_out,
	output pac_pkg::pac_pin_t select_or_active_pin,
	output logic clk_out_en,
	output logic [`PAC_STAT_W-1:0] status,
	output logic lock_loss_set
);
	logic in1_bad, in2_bad, bad_sel, active_r, active_nxt, sel_r, irq_act, lock_r;

	assign in1_bad = alarm.signal_loss_alarm1 | alarm.frequency_offset_alarm1;
	assign in2_bad = alarm.signal_loss_alarm2 | alarm.frequency_offset_alarm2;
	assign bad_sel = active_r ? in2_bad : in1_bad; // [RULE6]
	assign irq_act = bad_sel & ~ctrl[`PAC_B_IRQ_MASK]; // [RULE5]

	// Automatic switch; both bad keeps the last good choice
	always_comb
	begin
		active_nxt = active_r;
		if (!ctrl[`PAC_B_AUTO])
			active_nxt = sel_r;
		else if (in1_bad && !in2_bad)
			active_nxt = 1'b1;
		else if (in2_bad && !in1_bad)
			active_nxt = 1'b0; // [RULE16]
	end

	// Manual choice from pin or register
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
			sel_r <= 1'b0;
		else if (!qrst_n)
			sel_r <= 1'b0; // [RULE1]
		else
			sel_r <= ctrl[`PAC_B_PIN_SEL] ? select_pin_in : ctrl[`PAC_B_REG_SEL]; // [RULE12] [RULE13]

	// Active input and lock state
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
		begin
			active_r <= 1'b0;
			lock_r <= 1'b0;
		end
		else if (!qrst_n)
		begin
			active_r <= 1'b0; // [RULE1]
			lock_r <= 1'b0;
		end
		else
		begin
			active_r <= active_nxt; // [RULE15]
			lock_r <= alarm.lock_loss;
		end

	// Pin drivers and status
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
		begin
			irq_pin <= '0;
			lock_loss_out <= '0;
			select_or_active_pin <= '0;
			clk_out_en <= 1'b0;
			status <= '0;
			lock_loss_set <= 1'b0;
		end
		else
		begin
			irq_pin.oe <= qrst_n & ctrl[`PAC_B_IRQ_EN]; // [RULE4] [RULE7]
			irq_pin.o <= irq_act ^ ~ctrl[`PAC_B_IRQ_POLARITY] ^ ctrl[`PAC_B_BAD_POL]; // [RULE5]
			lock_loss_out.oe <= qrst_n & ctrl[`PAC_B_LOL_EN]; // [RULE8] [RULE9]
			lock_loss_out.o <= lock_r ^ ~ctrl[`PAC_B_LOCK_LOSS_POLARITY]; // [RULE10]
			select_or_active_pin.oe <= qrst_n & ctrl[`PAC_B_AUTO] & ctrl[`PAC_B_ACT_EN]; // [RULE17] [RULE13]
			select_or_active_pin.o <= active_r; // [RULE15]
			clk_out_en <= qrst_n & ctrl[`PAC_B_PROG]; // [RULE2] [RULE3]
			status[`PAC_S_LOCK_LOSS] <= lock_r; // [RULE11]
			status[`PAC_S_ACTIVE] <= active_r; // [RULE18]
			status[`PAC_S_ALARM] <= bad_sel;
			status[`PAC_S_SEL] <= sel_r;
			status[`PAC_S_RESET] <= ~qrst_n;
			lock_loss_set <= qrst_n & lock_r; // [RULE20]
		end
endmodule
`default_nettype wire

// >>> pac_top.sv
// What the document asks of this block and of its host
// RULE1: Quadrant reset pin returns logic and configuration to defaults.
// RULE2: Clock outputs are tri-stated while reset is held.
// RULE3: No output clock until host programs the configuration.
// RULE4: Interrupt pin drives only when its enable bit is one.
// RULE5: Interrupt is maskable; asserted level follows polarity bit.
// RULE6: Interrupt reads 0 with clock present, 1 on loss or offset alarm.
// RULE7: Interrupt pin tri-states when no function is selected.
// RULE8: Enabled lock-loss pin shows 0 locked, 1 unlocked.
// RULE9: Lock-loss pin tri-states when its enable is zero.
// RULE10: Lock-loss pin asserted level follows its polarity bit.
// RULE11: Lock status always readable in a read-only bit.
// RULE12: Manual mode with pin select: pin 0 first input, 1 second.
// RULE13: Pin select zero: register bit selects, device leaves pin undriven.
// RULE14: Host holds select pin at a defined level when an input.
// RULE15: Automatic mode: pin reports active input, 0 first, 1 second.
// RULE16: Both inputs in alarm keeps the last active input shown.
// RULE17: Active input driven on pin only when its enable is one.
// RULE18: Active input always readable in a read-only bit.
// RULE19: Serial target: clock input only, data bidirectional.
// RULE20: Sticky lock-loss flag stays set until host writes zero.
// RULE21: Host waits 10 ms after software reset before accessing.
// RULE22: Each of four quadrants has its own pins and control bits.
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pac_defs.svh"
module pac_top #(
	parameter int NQ = 4,
	parameter int SWRST_CYC = `PAC_SWRST_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic [NQ-1:0] quadrant_reset_n,
	input wire pac_pkg::pac_alarm_t [NQ-1:0] alarm,
	input wire logic [NQ-1:0] select_pin_in,
	output pac_pkg::pac_pin_t [NQ-1:0] irq_pin,
	output pac_pkg::pac_pin_t [NQ-1:0] lock_loss_out,
	output pac_pkg::pac_pin_t [NQ-1:0] select_or_active_pin,
	output logic [NQ-1:0] clk_out_en
);
	logic [NQ-1:0] rst_s1, rst_s2, sel_s1, sel_s2, lls_set, sticky_r, qrst;
	logic [`PAC_CTRL_W-1:0] ctrl_r [NQ];
	logic [`PAC_STAT_W-1:0] stat [NQ];
	pac_pkg::pac_alarm_t [NQ-1:0] al_s1, al_s2;
	logic [31:0] rst_cnt_r;
	pac_pkg::pac_rst_state_t rst_state_r;
	logic [1:0] qidx;
	logic [3:0] reg_off;
	logic hit, wr_acc;

	// Byte address: bits 5:4 quadrant, bits 3:0 register
	assign qidx = wb_adr_i[5:4];
	assign reg_off = wb_adr_i[3:0];
	assign hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_acc = hit & wb_we_i & wb_sel_i[0];

	// Two-stage synchronisers for pins; reset pins idle high, so no false reset follows rstn
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
		begin
			rst_s1 <= '1;
			rst_s2 <= '1;
			sel_s1 <= '0;
			sel_s2 <= '0;
			al_s1 <= '0;
			al_s2 <= '0;
		end
		else
		begin
			rst_s1 <= quadrant_reset_n;
			rst_s2 <= rst_s1;
			sel_s1 <= select_pin_in; // [RULE14]
			sel_s2 <= sel_s1;
			al_s1 <= alarm;
			al_s2 <= al_s1;
		end

	// Software reset holds all quadrants for the quiet time
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
		begin
			rst_state_r <= pac_pkg::PAC_IDLE;
			rst_cnt_r <= '0;
		end
		else
			case (rst_state_r)
				pac_pkg::PAC_IDLE:
					if (wr_acc && reg_off == `PAC_REG_SWRST && wb_dat_i[0])
					begin
						rst_state_r <= pac_pkg::PAC_HOLD; // [RULE21]
						rst_cnt_r <= 32'(SWRST_CYC - 1);
					end
				pac_pkg::PAC_HOLD:
					if (rst_cnt_r == '0)
						rst_state_r <= pac_pkg::PAC_IDLE;
					else
						rst_cnt_r <= rst_cnt_r - 32'h1;
				default:
					rst_state_r <= pac_pkg::PAC_IDLE;
			endcase

	// Effective per-quadrant reset: pin or software
	assign qrst = rst_s2 & {NQ{rst_state_r == pac_pkg::PAC_IDLE}};

	genvar g;
	generate
		for (g = 0; g < NQ; g++)
		begin : gq
			// Control word and sticky flag of one quadrant
			always_ff @(posedge sys_clk or negedge rstn)
				if (!rstn)
				begin
					ctrl_r[g] <= `PAC_CTRL_RST;
					sticky_r[g] <= 1'b0;
				end
				else if (!qrst[g])
				begin
					ctrl_r[g] <= `PAC_CTRL_RST; // [RULE1]
					sticky_r[g] <= 1'b0;
				end
				else
				begin
					if (wr_acc && qidx == 2'(g) && reg_off == `PAC_REG_CTRL)
						ctrl_r[g] <= wb_dat_i[`PAC_CTRL_W-1:0];
					if (lls_set[g])
						sticky_r[g] <= 1'b1; // [RULE20]
					else if (wr_acc && qidx == 2'(g) && reg_off == `PAC_REG_FLAG && !wb_dat_i[0])
						sticky_r[g] <= 1'b0;
				end

			pac_quadrant u_q (
				.sys_clk(sys_clk),
				.rstn(rstn),
				.qrst_n(qrst[g]),
				.ctrl(ctrl_r[g]),
				.alarm(al_s2[g]),
				.select_pin_in(sel_s2[g]),
				.irq_pin(irq_pin[g]),
				.lock_loss_out(lock_loss_out[g]),
				.select_or_active_pin(select_or_active_pin[g]),
				.clk_out_en(clk_out_en[g]),
				.status(stat[g]),
				.lock_loss_set(lls_set[g])
			); // [RULE22]
		end
	endgenerate

	// Single-wait-state Wishbone slave; unmapped reads return zero
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= hit; // [RULE19]
			wb_dat_o <= '0;
			if (hit && !wb_we_i && wb_adr_i[31:6] == '0)
				case (reg_off)
					`PAC_REG_CTRL: wb_dat_o <= 32'(ctrl_r[qidx]);
					`PAC_REG_STAT: wb_dat_o <= 32'(stat[qidx]); // [RULE11] [RULE18]
					`PAC_REG_FLAG: wb_dat_o <= 32'(sticky_r[qidx]);
					`PAC_REG_SWRST: wb_dat_o <= 32'(rst_state_r == pac_pkg::PAC_HOLD);
					default: wb_dat_o <= '0;
				endcase
		end
	// This register bus stands in for the serial target port
endmodule
`default_nettype wire

// >>> pac_board.sv
`timescale 1ns/100ps
`default_nettype none
// Board side of the select pins: host strap unless the device drives
module pac_board (
	input wire logic [3:0] host_sel,
	input wire pac_pkg::pac_pin_t [3:0] pin,
	output logic [3:0] select_pin_in
);
	// Wire level seen by the device input buffer
	always_comb
		for (int q = 0; q < 4; q++)
			select_pin_in[q] = pin[q].oe ? pin[q].o : host_sel[q];
endmodule
`default_nettype wire

// >>> pac_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
// Checks on quadrant 0 pins and the register bus
module pac_top_chk #(
	parameter int NQ = 4
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [NQ-1:0] quadrant_reset_n,
	input wire pac_pkg::pac_alarm_t [NQ-1:0] alarm,
	input wire pac_pkg::pac_pin_t [NQ-1:0] irq_pin,
	input wire pac_pkg::pac_pin_t [NQ-1:0] lock_loss_out,
	input wire pac_pkg::pac_pin_t [NQ-1:0] select_or_active_pin,
	input wire logic [NQ-1:0] clk_out_en
);
	logic [10:0] ctrl_r;
	logic wr;
	// A write completes at the ack edge
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	// Shadow of the quadrant 0 control word, cleared by either reset
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
			ctrl_r <= 11'h000;
		else if (!quadrant_reset_n[0] || (wr && wb_adr_i[3:0] == 4'hC && wb_dat_i[0]))
			ctrl_r <= 11'h000;
		else if (wr && wb_adr_i == 32'h00000000)
			ctrl_r <= wb_dat_i[10:0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	ack_take_a: assert property (req_s |=> wb_ack_o) else $error("request not acked");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	qrst_off_a: assert property ((!quadrant_reset_n[0])[*5] |-> !clk_out_en[0] &&
		!irq_pin[0].oe && !lock_loss_out[0].oe && !select_or_active_pin[0].oe)
		else $error("outputs driven in reset");
	no_clk_a: assert property ((!ctrl_r[10])[*8] |-> !clk_out_en[0])
		else $error("clock out while unprogrammed");
	lol_tri_a: assert property ((!ctrl_r[4])[*8] |-> !lock_loss_out[0].oe)
		else $error("lock pin driven while off");
	irq_tri_a: assert property ((!ctrl_r[0])[*8] |-> !irq_pin[0].oe)
		else $error("irq pin driven while off");
	sel_tri_a: assert property ((!ctrl_r[8] || !ctrl_r[9])[*8]
		|-> !select_or_active_pin[0].oe) else $error("select pin driven");
	lol_level_a: assert property ((ctrl_r[4] && quadrant_reset_n[0] && $stable(ctrl_r)
		&& $stable(alarm[0].lock_loss))[*8] |-> lock_loss_out[0].oe
		&& lock_loss_out[0].o == (alarm[0].lock_loss ~^ ctrl_r[5])) else $error("lock level");
endmodule
`default_nettype wire

// >>> tb_pac_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_pac_top;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [31:0] wb_adr_i = 32'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic [31:0] rd;
	logic [3:0] wb_sel_i = 4'hF;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_ack_o;
	logic [3:0] quadrant_reset_n = 4'hF;
	logic [3:0] host_sel = 4'h0;
	logic [3:0] select_pin_in;
	logic [3:0] clk_out_en;
	pac_pkg::pac_alarm_t [3:0] alarm = 20'h0;
	pac_pkg::pac_pin_t [3:0] irq_pin;
	pac_pkg::pac_pin_t [3:0] lock_loss_out;
	pac_pkg::pac_pin_t [3:0] select_or_active_pin;
	int num_errors = 0;
	int samples_checked = 0;
	int cyc_cnt = 0;
	pac_top #(.NQ(4), .SWRST_CYC(20)) u_dut (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_sel_i(wb_sel_i),
		.wb_we_i(wb_we_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_ack_o(wb_ack_o),
		.quadrant_reset_n(quadrant_reset_n),
		.alarm(alarm),
		.select_pin_in(select_pin_in),
		.irq_pin(irq_pin),
		.lock_loss_out(lock_loss_out),
		.select_or_active_pin(select_or_active_pin),
		.clk_out_en(clk_out_en)
	);
	pac_board u_board (.host_sel(host_sel), .pin(select_or_active_pin),
		.select_pin_in(select_pin_in));
	always #4 sys_clk = ~sys_clk;
	// Hang guard
	always @(posedge sys_clk)
	begin
		cyc_cnt++;
		if (cyc_cnt == 3000)
		begin
			num_errors++;
			finish_test();
		end
	end
	// One classic cycle, held until ack is sampled
	task automatic wb(input logic [31:0] a, input logic [31:0] d, input logic w);
		@(posedge sys_clk);
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		wb_we_i <= w;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do
			@(posedge sys_clk);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	// Wait out the pin latency, then settle
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic t_lol;
		wb(32'h0, 32'h30, 1'b1);
		alarm[0].lock_loss <= 1'b1;
		wt(8);
		`CHK("lol_high", 2'b11, lock_loss_out[0])
		wb(32'h0, 32'h10, 1'b1);
		wt(8);
		`CHK("lol_low", 2'b01, lock_loss_out[0])
		wb(32'h0, 32'h0, 1'b1);
		wb(32'h4, 32'h0, 1'b0);
		`CHK("lol_stat", 1'b1, rd[0])
		alarm[0].lock_loss <= 1'b0;
		wt(8);
		wb(32'h8, 32'h0, 1'b0);
		`CHK("sticky", 1'b1, rd[0])
		wb(32'h8, 32'h0, 1'b1);
		wb(32'h8, 32'h0, 1'b0);
		`CHK("sticky_clr", 1'b0, rd[0])
		$display("test lol done");
	endtask
	task automatic t_irq;
		wb(32'h0, 32'h3, 1'b1);
		for (int k = 0; k < 3; k++)
		begin
			alarm[0] <= (k == 0) ? 5'h08 : (k == 1) ? 5'h04 : 5'h00;
			wt(8);
			`CHK("irq_level", {k < 2, 1'b1}, irq_pin[0])
		end
		alarm[0] <= 5'h08;
		wb(32'h0, 32'hB, 1'b1);
		wt(8);
		`CHK("irq_mask", 2'b01, irq_pin[0])
		wb(32'h0, 32'h7, 1'b1);
		wt(8);
		`CHK("irq_badpol", 2'b01, irq_pin[0])
		wb(32'h0, 32'h2, 1'b1);
		wt(8);
		`CHK("irq_off", 1'b0, irq_pin[0].oe)
		$display("test irq done");
	endtask
	task automatic t_sel;
		alarm[0] <= 5'h00;
		host_sel[0] <= 1'b1;
		wb(32'h0, 32'h40, 1'b1);
		wt(8);
		wb(32'h4, 32'h0, 1'b0);
		`CHK("pin_sel", 1'b1, rd[1])
		`CHK("pin_in", 1'b0, select_or_active_pin[0].oe)
		host_sel[0] <= 1'b0;
		wb(32'h0, 32'h80, 1'b1);
		wt(8);
		wb(32'h4, 32'h0, 1'b0);
		`CHK("reg_sel", 1'b1, rd[1])
		wb(32'h0, 32'h300, 1'b1);
		alarm[0] <= 5'h02;
		wt(8);
		`CHK("auto_first", 2'b01, select_or_active_pin[0])
		alarm[0] <= 5'h08;
		wt(8);
		`CHK("auto_act", 2'b11, select_or_active_pin[0])
		alarm[0] <= 5'h0A;
		wt(8);
		`CHK("hold_act", 2'b11, select_or_active_pin[0])
		wb(32'h0, 32'h100, 1'b1);
		wt(8);
		`CHK("act_off", 1'b0, select_or_active_pin[0].oe)
		wb(32'h4, 32'h0, 1'b0);
		`CHK("act_stat", 1'b1, rd[1])
		alarm[0] <= 5'h00;
		$display("test select done");
	endtask
	task automatic t_rst;
		`CHK("out_en_init", 4'h0, clk_out_en)
		wb(32'h0, 32'h400, 1'b1);
		wb(32'h10, 32'h400, 1'b1);
		wt(8);
		`CHK("out_en", 4'h3, clk_out_en)
		quadrant_reset_n[0] <= 1'b0;
		wt(8);
		`CHK("qrst_tri", 4'h2, clk_out_en)
		quadrant_reset_n[0] <= 1'b1;
		wt(4);
		wb(32'h0, 32'h0, 1'b0);
		`CHK("qrst_ctrl", 32'h0, rd)
		wb(32'h10, 32'h0, 1'b0);
		`CHK("other_quad", 32'h400, rd)
		wb(32'h40, 32'h0, 1'b0);
		`CHK("unmapped", 32'h0, rd)
		wb(32'h1C, 32'h1, 1'b1);
		wb(32'h0C, 32'h0, 1'b0);
		`CHK("swrst_busy", 1'b1, rd[0])
		wt(30);
		wb(32'h10, 32'h0, 1'b0);
		`CHK("swrst_ctrl", 32'h0, rd)
		$display("test reset done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		t_rst();
		t_lol();
		t_irq();
		t_sel();
		finish_test();
	end
endmodule
bind pac_top pac_top_chk #(.NQ(NQ)) u_chk (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i),
	.wb_sel_i(wb_sel_i),
	.wb_we_i(wb_we_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.quadrant_reset_n(quadrant_reset_n),
	.alarm(alarm),
	.irq_pin(irq_pin),
	.lock_loss_out(lock_loss_out),
	.select_or_active_pin(select_or_active_pin),
	.clk_out_en(clk_out_en)
);
`default_nettype wire
